// File: inc/msi_pkg.sv
package msi_pkg;

  // Function codes and exception codes
  localparam logic [7:0]  FC_ID        = 8'h11;
  localparam logic [7:0]  FC_RW        = 8'h17;
  localparam logic [7:0]  EXC_FLAG     = 8'h80;
  localparam logic [7:0]  EXC_ILL_FN   = 8'h01;
  localparam logic [7:0]  EXC_ADDR     = 8'h02;
  localparam logic [7:0]  EXC_VALUE    = 8'h03;
  localparam logic [7:0]  EXC_FAIL     = 8'h04;
  localparam logic [7:0]  EXC_NONE     = 8'h00;

  // Report Server ID payload and reply lengths
  localparam logic [7:0]  RUN_ON       = 8'hff;
  localparam logic [7:0]  RUN_OFF      = 8'h00;
  localparam logic [7:0]  ID_BYTE_CNT  = 8'h02;
  localparam logic [7:0]  ID_RSP_LEN   = 8'h05;
  localparam logic [7:0]  EXC_RSP_LEN  = 8'h03;
  localparam logic [7:0]  RW_RSP_HDR   = 8'h03;

  // Request layout: byte positions and lengths
  localparam logic [8:0]  ID_REQ_LEN   = 9'h004;
  localparam logic [8:0]  MIN_FRAME    = 9'h004;
  // Fixed 17h bytes: eleven header bytes plus two CRC bytes
  localparam logic [8:0]  RW_FIXED_LEN = 9'h00d;
  localparam logic [7:0]  RW_RA_POS    = 8'h02;
  localparam logic [7:0]  RW_RQ_POS    = 8'h04;
  localparam logic [7:0]  RW_WA_POS    = 8'h06;
  localparam logic [7:0]  RW_WQ_POS    = 8'h08;
  localparam logic [7:0]  RW_BC_POS    = 8'h0a;
  localparam logic [7:0]  RW_DATA_OFS  = 8'h0b;

  // Quantity limits for the combined function
  localparam logic [15:0] QTY_MIN      = 16'h0001;
  localparam int unsigned QTY_MAX      = 121;

  // CRC-16, reflected polynomial
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'ha001;

  // Register access request toward the object store
  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [15:0] wdata;
  } msi_reg_req_t;

  typedef enum logic [2:0] {
    S_RX, S_EXEC, S_WR, S_WR_WAIT, S_RD, S_RD_WAIT, S_SEND
  } msi_state_t;

  // One byte through the CRC, LSB first
  function automatic logic [15:0] msi_crc_byte(input logic [15:0] c,
                                               input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : msi_crc_byte

endpackage : msi_pkg

// File: src/msi_server_fn.sv
`timescale 1ns/1ps
module msi_server_fn
  import msi_pkg::*;
#(
  parameter logic [7:0]  ID_DATA   = 8'h5a, // Arbitrary identity byte
  parameter int unsigned QTY_LIMIT = QTY_MAX
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  // Device state
  input  wire logic [7:0]   own_addr_i,
  input  wire logic         run_on_i,
  input  wire logic         dev_fault_i,
  // Received bytes from the serial front end
  input  wire logic         rx_valid_i,
  input  wire logic [7:0]   rx_data_i,
  input  wire logic         rx_end_i,
  // Bytes to transmit
  output logic              tx_valid_o,
  output logic [7:0]        tx_data_o,
  input  wire logic         tx_ready_i,
  // Object store access, answered in the strobe cycle
  output msi_reg_req_t      reg_req_o,
  input  wire logic [15:0]  reg_rdata_i,
  input  wire logic         reg_err_i
);

  // Limit must fit the 7-bit counters and the frame buffer
  if (QTY_LIMIT < 1 || QTY_LIMIT > QTY_MAX) begin : g_qty_check
    $error("QTY_LIMIT out of range");
  end

  localparam logic [15:0] QTY_TOP = 16'(QTY_LIMIT);

  logic [7:0]   rx_buf [256];
  logic [7:0]   rd_buf [256];
  msi_state_t   st_q, st_d;
  logic [8:0]   rx_len_q, rx_len_d;
  logic [15:0]  rx_crc_q, rx_crc_d, tx_crc_q, tx_crc_d, crc_nx;
  logic [6:0]   idx_q, idx_d, rq_q, rq_d, wq_q, wq_d;
  logic [15:0]  rs_q, rs_d, ws_q, ws_d, rq16, wq16;
  logic [7:0]   fc_q, fc_d, exc_q, exc_d;
  logic [7:0]   tx_len_q, tx_len_d, tx_pos_q, tx_pos_d, tx_data_q, tx_data_d;
  logic [7:0]   wofs;
  logic [8:0]   rw_len;
  logic         tx_valid_q, tx_valid_d, rx_we, rd_we, go_send, frame_ok;
  msi_reg_req_t req_q, req_d;

  // Response byte at position p, header then payload
  function automatic logic [7:0] tx_byte(input logic [7:0] p);
    logic [7:0] r;
    r = rd_buf[8'(p - RW_RSP_HDR)];
    if (p == 8'h01) begin
      r = (exc_q != EXC_NONE) ? (fc_q | EXC_FLAG) : fc_q;
    end else if (p == 8'h02) begin
      r = (exc_q != EXC_NONE) ? exc_q :
          (fc_q == FC_ID) ? ID_BYTE_CNT : {rq_q, 1'b0};
    end else if (fc_q == FC_ID) begin
      r = (p == 8'h03) ? (run_on_i ? RUN_ON : RUN_OFF) : ID_DATA;
    end
    return r;
  endfunction : tx_byte

  assign rq16     = {rx_buf[RW_RQ_POS], rx_buf[RW_RQ_POS + 8'h01]};
  assign wq16     = {rx_buf[RW_WQ_POS], rx_buf[RW_WQ_POS + 8'h01]};
  assign wofs     = RW_DATA_OFS + {idx_q, 1'b0};
  // Expected 17h frame length from its own byte count
  assign rw_len   = RW_FIXED_LEN + {1'b0, rx_buf[RW_BC_POS]};
  // CRC residue of zero means the trailing CRC matched
  assign frame_ok = (rx_crc_q == 16'h0000) && (rx_len_q >= MIN_FRAME) &&
                    !rx_len_q[8] && (rx_buf[0] == own_addr_i);

  // Frame reception, command execution and reply sequencing
  always_comb begin
    st_d = st_q;  rx_len_d = rx_len_q;  rx_crc_d = rx_crc_q;
    idx_d = idx_q;  fc_d = fc_q;  exc_d = exc_q;  rq_d = rq_q;  wq_d = wq_q;
    rs_d = rs_q;  ws_d = ws_q;  tx_len_d = tx_len_q;  tx_pos_d = tx_pos_q;
    tx_crc_d = tx_crc_q;  tx_valid_d = tx_valid_q;  tx_data_d = tx_data_q;
    req_d = '0;  rx_we = 1'b0;  rd_we = 1'b0;  go_send = 1'b0;
    crc_nx = tx_crc_q;
    unique case (st_q)
      S_RX: begin
        if (rx_valid_i && !rx_len_q[8]) begin
          rx_we    = 1'b1;
          rx_len_d = rx_len_q + 9'h001;
          rx_crc_d = msi_crc_byte(rx_crc_q, rx_data_i);
        end
        if (rx_end_i) begin
          if (frame_ok) begin
            st_d = S_EXEC;
          end else begin
            rx_len_d = '0;
            rx_crc_d = CRC_INIT;
          end
        end
      end
      S_EXEC: begin
        fc_d = rx_buf[1];  exc_d = EXC_NONE;  idx_d = '0;
        rq_d = rq16[6:0];  wq_d = wq16[6:0];
        rs_d = {rx_buf[RW_RA_POS], rx_buf[RW_RA_POS + 8'h01]};
        ws_d = {rx_buf[RW_WA_POS], rx_buf[RW_WA_POS + 8'h01]};
        rx_len_d = '0;  rx_crc_d = CRC_INIT;  st_d = S_RX;
        if (rx_buf[1] == FC_ID && rx_len_q == ID_REQ_LEN) begin
          exc_d = dev_fault_i ? EXC_FAIL : EXC_NONE;
          go_send = 1'b1;
        end else if (rx_buf[1] == FC_RW) begin
          if (dev_fault_i) begin
            exc_d = EXC_FAIL;
          end else if (rq16 < QTY_MIN || rq16 > QTY_TOP ||
                       wq16 < QTY_MIN || wq16 > QTY_TOP ||
                       rx_buf[RW_BC_POS] != {wq16[6:0], 1'b0} ||
                       rx_len_q != rw_len) begin
            exc_d = EXC_VALUE;
          end
          go_send = (exc_d != EXC_NONE);
          if (exc_d == EXC_NONE) begin
            st_d = S_WR;
          end
        end
      end
      S_WR: begin
        req_d.we    = 1'b1;
        req_d.addr  = ws_q + 16'(idx_q);
        req_d.wdata = {rx_buf[wofs], rx_buf[8'(wofs + 8'h01)]};
        st_d = S_WR_WAIT;
      end
      S_WR_WAIT: begin
        if (reg_err_i) begin
          exc_d = EXC_ADDR;
          go_send = 1'b1;
        end else if (idx_q == 7'(wq_q - 7'h01)) begin
          idx_d = '0;
          st_d = S_RD;
        end else begin
          idx_d = idx_q + 7'h01;
          st_d = S_WR;
        end
      end
      S_RD: begin
        req_d.re   = 1'b1;
        req_d.addr = rs_q + 16'(idx_q);
        st_d = S_RD_WAIT;
      end
      S_RD_WAIT: begin
        rd_we = 1'b1;
        if (reg_err_i) begin
          exc_d = EXC_ADDR;
          go_send = 1'b1;
        end else if (idx_q == 7'(rq_q - 7'h01)) begin
          go_send = 1'b1;
        end else begin
          idx_d = idx_q + 7'h01;
          st_d = S_RD;
        end
      end
      S_SEND: begin
        if (tx_ready_i) begin
          crc_nx = (tx_pos_q < tx_len_q) ?
                   msi_crc_byte(tx_crc_q, tx_data_q) : tx_crc_q;
          tx_crc_d = crc_nx;
          tx_pos_d = tx_pos_q + 8'h01;
          if (tx_pos_d < tx_len_q) begin
            tx_data_d = tx_byte(tx_pos_d);
          end else begin
            // Low CRC byte goes first
            tx_data_d = (tx_pos_d == tx_len_q) ? crc_nx[7:0] :
                        crc_nx[15:8];
          end
          if (tx_pos_q == tx_len_q + 8'h01) begin
            tx_valid_d = 1'b0;
            st_d = S_RX;
          end
        end
      end
      // Eighth code of the state word is never used
      default: st_d = S_RX;
    endcase
    // Reply start, shared by every path that answers
    if (go_send) begin
      st_d = S_SEND;  tx_pos_d = '0;  tx_crc_d = CRC_INIT;
      tx_valid_d = 1'b1;  tx_data_d = rx_buf[0];
      tx_len_d = (exc_d != EXC_NONE) ? EXC_RSP_LEN :
                 (fc_d == FC_ID) ? ID_RSP_LEN :
                 RW_RSP_HDR + {rq_q, 1'b0};
    end
  end

  // State registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= S_RX;  rx_len_q <= '0;  rx_crc_q <= CRC_INIT;  idx_q <= '0;
      fc_q <= '0;  exc_q <= '0;  rq_q <= '0;  wq_q <= '0;  rs_q <= '0;
      ws_q <= '0;  tx_len_q <= '0;  tx_pos_q <= '0;  tx_crc_q <= CRC_INIT;
      tx_valid_q <= 1'b0;  tx_data_q <= '0;  req_q <= '0;
    end else begin
      st_q <= st_d;  rx_len_q <= rx_len_d;  rx_crc_q <= rx_crc_d;
      idx_q <= idx_d;  fc_q <= fc_d;  exc_q <= exc_d;  rq_q <= rq_d;
      wq_q <= wq_d;  rs_q <= rs_d;  ws_q <= ws_d;  tx_len_q <= tx_len_d;
      tx_pos_q <= tx_pos_d;  tx_crc_q <= tx_crc_d;  tx_valid_q <= tx_valid_d;
      tx_data_q <= tx_data_d;  req_q <= req_d;
    end
  end

  // Frame and read-data memories; no reset needed, length gates use
  always_ff @(posedge clk_i) begin
    if (rx_we) begin
      rx_buf[rx_len_q[7:0]] <= rx_data_i;
    end
    if (rd_we) begin
      rd_buf[{idx_q, 1'b0}]        <= reg_rdata_i[15:8];
      rd_buf[{idx_q, 1'b0} + 8'h01] <= reg_rdata_i[7:0];
    end
  end

  assign tx_valid_o = tx_valid_q;
  assign tx_data_o  = tx_data_q;
  assign reg_req_o  = req_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_bad_crc_drop: assert property ((st_q == S_RX) && rx_end_i &&
      (rx_crc_q != 16'h0000) |=> (st_q == S_RX) && !tx_valid_o)
    else $error("frame with bad CRC was accepted");
  a_id_reply_len: assert property ((st_q == S_EXEC) &&
      (rx_buf[1] == FC_ID) && (rx_len_q == ID_REQ_LEN) && !dev_fault_i
      |=> (st_q == S_SEND) && (tx_len_q == ID_RSP_LEN))
    else $error("ID reply has wrong length");
  a_run_byte: assert property ((st_q == S_SEND) && (fc_q == FC_ID) &&
      (exc_q == EXC_NONE) && (tx_pos_q == 8'h03)
      |-> tx_data_o == (run_on_i ? RUN_ON : RUN_OFF))
    else $error("run indicator byte wrong");
  a_exc_code: assert property ((st_q == S_SEND) && (exc_q != EXC_NONE) &&
      (tx_pos_q == 8'h01) |-> tx_data_o == (fc_q | EXC_FLAG))
    else $error("exception function code lacks top bit");
  a_qty_range: assert property ((st_q == S_EXEC) && (rx_buf[1] == FC_RW) &&
      !dev_fault_i && ((rq16 > QTY_TOP) || (wq16 > QTY_TOP))
      |=> (exc_q == EXC_VALUE) && (st_q == S_SEND))
    else $error("quantity over limit not refused");
  a_wr_then_rd: assert property (req_q.re |-> !req_q.we &&
      $past(st_q, 2) inside {S_WR_WAIT, S_RD_WAIT})
    else $error("read strobe out of order");
  a_wr_addr: assert property (req_q.we |->
      req_q.addr == {rx_buf[RW_WA_POS], rx_buf[RW_WA_POS + 8'h01]} +
      16'(idx_q))
    else $error("write address not start plus index");
  a_unmapped: assert property ((st_q inside {S_WR_WAIT, S_RD_WAIT}) &&
      reg_err_i |=> (exc_q == EXC_ADDR) && (st_q == S_SEND) && tx_valid_o)
    else $error("unmapped object not refused");
  a_rw_count: assert property ((st_q == S_SEND) && (fc_q == FC_RW) &&
      (exc_q == EXC_NONE) |-> tx_len_q == RW_RSP_HDR + {rq_q, 1'b0})
    else $error("read count in reply wrong");

  c_id_reply:  cover property ((st_q == S_SEND) && (fc_q == FC_ID) &&
                               !tx_valid_d);
  c_rw_reply:  cover property ((st_q == S_SEND) && (fc_q == FC_RW) &&
                               (exc_q == EXC_NONE) && !tx_valid_d);
  c_exception: cover property ((st_q == S_SEND) && (exc_q != EXC_NONE));
  c_bad_crc:   cover property ((st_q == S_RX) && rx_end_i && !frame_ok);

endmodule : msi_server_fn

// File: verification/msi_obj_store_model.sv
`timescale 1ns/1ps
module msi_obj_store_model
  import msi_pkg::*;
(
  // Clock
  input  wire logic         clk_i,
  // Access from the block
  input  wire msi_reg_req_t reg_req_i,
  output logic [15:0]       rdata_o,
  output logic              err_o
);
  logic [15:0] mem [4096];
  logic [15:0] last_q;

  // Upper half of the address space is not mapped
  assign err_o = (reg_req_i.we | reg_req_i.re) & reg_req_i.addr[15];
  // Read data only valid with the strobe, otherwise garbage
  assign rdata_o = reg_req_i.re ? mem[reg_req_i.addr[11:0]] : ~last_q;

  // Known start pattern so reads can be predicted
  initial begin
    last_q = 16'h0000;
    for (int i = 0; i < 4096; i++) mem[i] = 16'h4000 + 16'(i);
  end

  // Store 16-bit words, remember last read
  always @(posedge clk_i) begin
    if (reg_req_i.re) last_q <= rdata_o;
    if (reg_req_i.we && !reg_req_i.addr[15]) begin
      mem[reg_req_i.addr[11:0]] <= reg_req_i.wdata;
    end
  end
endmodule : msi_obj_store_model

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import msi_pkg::*;
  logic         clk_i, arst_n_i, run_on_i, dev_fault_i;
  logic         rx_valid_i, rx_end_i, tx_valid_o, tx_ready_i, reg_err_i;
  logic [7:0]   own_addr_i, rx_data_i, tx_data_o;
  logic [15:0]  reg_rdata_i;
  msi_reg_req_t reg_req_o;
  logic [7:0]   fq[$];
  logic [7:0]   eq[$];
  int           fails, compares;
  bit           stall;

  msi_server_fn msi_server_fn_i (.clk_i, .arst_n_i, .own_addr_i, .run_on_i,
    .dev_fault_i, .rx_valid_i, .rx_data_i, .rx_end_i, .tx_valid_o,
    .tx_data_o, .tx_ready_i, .reg_req_o, .reg_rdata_i, .reg_err_i);
  msi_obj_store_model msi_obj_store_model_i (.clk_i, .reg_req_i(reg_req_o),
    .rdata_o(reg_rdata_i), .err_o(reg_err_i));

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Own CRC model, kept apart from the design's helper
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc16

  task automatic check(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Client side: frame, CRC low byte first, then end pulse
  task automatic send(input bit bad);
    logic [15:0] c;
    c = crc16(fq) ^ {15'h0000, bad};
    fq.push_back(c[7:0]);
    fq.push_back(c[15:8]);
    foreach (fq[i]) begin
      rx_valid_i = 1'b1;
      rx_data_i = fq[i];
      @(posedge clk_i);
      #1;
    end
    rx_valid_i = 1'b0;
    rx_end_i = 1'b1;
    @(posedge clk_i);
    #1;
    rx_end_i = 1'b0;
    fq.delete();
  endtask : send

  // Collect a reply, sink stalls every other cycle when asked
  task automatic reply();
    logic [15:0] c;
    int n, t;
    c = crc16(eq);
    eq.push_back(c[7:0]);
    eq.push_back(c[15:8]);
    n = 0;
    t = 0;
    while (n < eq.size() && t < 3000) begin
      tx_ready_i = !stall || t[0];
      @(posedge clk_i);
      if (tx_valid_o === 1'b1 && tx_ready_i) begin
        check("tx_data_o", {8'h00, tx_data_o}, {8'h00, eq[n]});
        n++;
      end
      #1;
      t++;
    end
    check("reply_len", 16'(n), 16'(eq.size()));
    check("tx_valid_o", {15'h0000, tx_valid_o}, 16'h0000);
    tx_ready_i = 1'b1;
    eq.delete();
  endtask : reply

  // No reply and no store access may follow
  task automatic silent();
    repeat (40) begin
      @(posedge clk_i);
      check("idle", {13'h0, tx_valid_o, reg_req_o.we, reg_req_o.re},
            16'h0000);
    end
    #1;
  endtask : silent

  task automatic rw(input logic [15:0] ra, rq, wa, wq, input logic [7:0] bc,
                    input int nw, input logic [15:0] w0);
    logic [15:0] w;
    fq = {8'h05, FC_RW, ra[15:8], ra[7:0], rq[15:8], rq[7:0],
          wa[15:8], wa[7:0], wq[15:8], wq[7:0], bc};
    for (int i = 0; i < nw; i++) begin
      w = w0 + 16'(i) * 16'h0202;
      fq.push_back(w[15:8]);
      fq.push_back(w[7:0]);
    end
    send(1'b0);
  endtask : rw

  task automatic exc(input logic [7:0] fn, code);
    eq = {8'h05, fn, code};
    reply();
  endtask : exc

  // Identification reply with run byte on and off
  task automatic t_id();
    for (int k = 0; k < 2; k++) begin
      run_on_i = (k == 0);
      stall = (k == 1);
      fq = {8'h05, FC_ID};
      check("req_crc", crc16(fq), 16'hecc2);
      send(1'b0);
      eq = {8'h05, 8'h11, 8'h02, (k == 0) ? 8'hff : 8'h00, 8'h5a};
      reply();
    end
    stall = 1'b0;
  endtask : t_id

  // Device fault gives code 04 on both functions
  task automatic t_fault();
    dev_fault_i = 1'b1;
    fq = {8'h05, FC_ID};
    send(1'b0);
    exc(8'h91, 8'h04);
    rw(16'h0000, 16'h0001, 16'h0000, 16'h0001, 8'h02, 1, 16'h1111);
    exc(8'h97, 8'h04);
    dev_fault_i = 1'b0;
  endtask : t_fault

  // Write lands before the read of the same words; largest read
  task automatic t_rw_ok();
    rw(16'h1770, 16'h0002, 16'h1770, 16'h0002, 8'h04, 2, 16'h0102);
    eq = {8'h05, 8'h17, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04};
    reply();
    stall = 1'b1;
    rw(16'h0000, 16'h0079, 16'h00ff, 16'h0001, 8'h02, 1, 16'h2222);
    eq = {8'h05, 8'h17, 8'hf2};
    for (int a = 0; a < 121; a++) eq = {eq, 8'h40, 8'(a)};
    reply();
    stall = 1'b0;
  endtask : t_rw_ok

  // Out-of-range counts, a mismatched byte count and unmapped places
  task automatic t_err();
    rw(16'h0000, 16'h0000, 16'h0010, 16'h0001, 8'h02, 1, 16'h1111);
    exc(8'h97, 8'h03);
    rw(16'h0000, 16'h007a, 16'h0010, 16'h0001, 8'h02, 1, 16'h1111);
    exc(8'h97, 8'h03);
    rw(16'h0000, 16'h0001, 16'h0010, 16'h0000, 8'h00, 0, 16'h1111);
    exc(8'h97, 8'h03);
    // Over-limit write count whose low bits alone match the byte count
    rw(16'h0000, 16'h0001, 16'h0010, 16'h0101, 8'h02, 1, 16'h1111);
    exc(8'h97, 8'h03);
    rw(16'h0000, 16'h0001, 16'h0010, 16'h0001, 8'h03, 1, 16'h1111);
    exc(8'h97, 8'h03);
    rw(16'h0000, 16'h0001, 16'h8000, 16'h0001, 8'h02, 1, 16'h1111);
    exc(8'h97, 8'h02);
    rw(16'hffff, 16'h0001, 16'h0010, 16'h0001, 8'h02, 1, 16'h1111);
    exc(8'h97, 8'h02);
  endtask : t_err

  // Bad CRC, foreign and broadcast address stay unanswered
  task automatic t_refuse();
    fq = {8'h05, FC_ID};
    send(1'b1);
    silent();
    fq = {8'h06, FC_ID};
    send(1'b0);
    silent();
    fq = {8'h00, FC_ID};
    send(1'b0);
    silent();
  endtask : t_refuse

  task automatic final_report();
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    arst_n_i = 1'b0;
    run_on_i = 1'b1;
    dev_fault_i = 1'b0;
    own_addr_i = 8'h05;
    rx_valid_i = 1'b0;
    rx_data_i = 8'h00;
    rx_end_i = 1'b0;
    tx_ready_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    t_id();
    t_fault();
    t_rw_ok();
    t_err();
    t_refuse();
    final_report();
  end

  // Whole run needs well under 20k cycles
  initial begin
    #200000;
    fails++;
    final_report();
  end
endmodule : testbench
